/* File: logic/goc_ctrl.v */
`timescale 1ns/1ps
`include "goc_map.vh"
// How it works
// - Sample period equals time base times seven-bit multiplier plus one
// - Bit 7 picks time base: 0 gives 1.953 ms, 1 gives 60.54 ms
// - Output data refresh at the internal sample rate, independent of reads
// - Sample period register resets to 0x0001, 256 samples per second
// - Below 64 samples per second the reduced-power mode is selected
// - Nonzero sleep count shuts the device down for count times half second
// - Sleep ends on its own when the count has elapsed
// - Chip-select low wakes early; host holds it high to stay asleep
// - Range/filter bits 3:0 hold exponent M; filter uses 2^M taps, with M capped at 7
// - Filter is two cascaded boxcar averages on the output data
// - Bits 10:8 pick range: 100 is 320, 010 is 160, 001 is 80
// - Exponent at least 2 for 160 range and 4 for 80 range
// - Range/filter register resets to 0x0402
// - DAC register holds a 12-bit code, upper four bits unused
// - DAC output keeps its code until the latch command
// - Command bit 2 copies the DAC register into the output latch
// - DAC register and latch return to zero on every reset
// - I/O control bits 0 and 1 set line direction, 1 is output
// - I/O control bits 8 and 9 set driven level of output lines
// - With lines as inputs, bits 0 and 1 read the pin levels
// - Line priority: data-ready/self-test, then alarm, then general I/O
module goc_ctrl #(
	parameter DW = 14,
	parameter TB_FAST_CYC = `GOC_TB_FAST_CYC,
	parameter TB_SLOW_CYC = `GOC_TB_SLOW_CYC,
	parameter SLEEP_LSB_CYC = `GOC_SLEEP_LSB_CYC
) (
	input wire sys_clk,
	input wire sys_rst,
	input wire wr_en,
	input wire [5:0] wr_addr,
	input wire [7:0] wr_data,
	input wire rd_en,
	input wire [5:0] rd_addr,
	output reg [15:0] rd_data,
	input wire cs_n_pin,
	input wire [1:0] io_pin_in,
	output reg [1:0] io_pin_out,
	output reg [1:0] io_pin_oe,
	input wire [1:0] drdy_claim,
	input wire [1:0] drdy_level,
	input wire [1:0] alarm_claim,
	input wire [1:0] alarm_level,
	input wire [DW-1:0] raw_data,
	output wire [DW-1:0] data_out,
	output wire data_update,
	output reg sample_strobe,
	output reg low_power_mode,
	output reg sleep_active,
	output reg [2:0] range_sel,
	output reg [3:0] filter_exp,
	output reg [11:0] dac_level
);
	localparam S_RUN = 2'd0;
	localparam S_ARM = 2'd1;
	localparam S_SLEEP = 2'd2;
	localparam [15:0] RST_DAC = `GOC_RST_DAC;
	localparam [15:0] RST_IO = `GOC_RST_IO;
	localparam [15:0] RST_SMPL = `GOC_RST_SMPL;
	localparam [15:0] RST_RANGE = `GOC_RST_RANGE;
	localparam [15:0] RST_SLEEP = `GOC_RST_SLEEP;

	reg [11:0] dac_code_reg;
	reg [1:0] io_dir_reg;
	reg [1:0] io_lvl_reg;
	reg [7:0] smpl_reg;
	reg [2:0] range_reg;
	reg [3:0] exp_reg;
	reg [7:0] sleep_reg;
	reg cs_meta_reg;
	reg cs_sync_reg;
	reg [1:0] io_meta_reg;
	reg [1:0] io_sync_reg;
	reg [31:0] tb_cnt_reg;
	reg [6:0] tick_cnt_reg;
	reg [1:0] state_reg;
	reg [31:0] half_cnt_reg;
	reg [7:0] remain_reg;
	reg [2:0] exp_prev_reg;
	reg [15:0] rd_next;
	reg [1:0] io_out_next;
	reg [1:0] io_oe_next;
	integer i;

	// Raise the exponent to the floor that a reduced range needs
	function [3:0] goc_floor;
		input [2:0] range;
		input [3:0] m;
		begin
			goc_floor = m;
			if (range == `GOC_RANGE_160 && m < `GOC_MIN_EXP_160)
				goc_floor = `GOC_MIN_EXP_160;
			if (range == `GOC_RANGE_80 && m < `GOC_MIN_EXP_80)
				goc_floor = `GOC_MIN_EXP_80;
		end
	endfunction

	wire wr_lo = wr_en && !wr_addr[0];
	wire [5:0] wr_word = {wr_addr[5:1], 1'b0};
	wire [5:0] rd_word = {rd_addr[5:1], 1'b0};
	wire smpl_wr = wr_en && wr_word == `GOC_ADDR_SMPL;
	wire [31:0] tb_len = smpl_reg[`GOC_SMPL_TB_BIT] ? TB_SLOW_CYC : TB_FAST_CYC;
	wire tb_tick = tb_cnt_reg == tb_len - 32'd1;
	wire period_done = tb_tick && tick_cnt_reg == smpl_reg[6:0];
	wire [3:0] exp_lim = (exp_reg > `GOC_MAX_EXP) ? `GOC_MAX_EXP : exp_reg;
	wire filt_restart = exp_lim[2:0] != exp_prev_reg;
	wire [DW-1:0] stage1_data;
	wire stage1_valid;

	// Two flip-flops before anything reads the pins
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			cs_meta_reg <= 1'b1;
			cs_sync_reg <= 1'b1;
			io_meta_reg <= 2'b00;
			io_sync_reg <= 2'b00;
		end else begin
			cs_meta_reg <= cs_n_pin;
			cs_sync_reg <= cs_meta_reg;
			io_meta_reg <= io_pin_in;
			io_sync_reg <= io_meta_reg;
		end
	end

	// Register writes arrive one byte at a time
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			dac_code_reg <= RST_DAC[11:0];
			dac_level <= RST_DAC[11:0];
			io_dir_reg <= RST_IO[1:0];
			io_lvl_reg <= RST_IO[9:8];
			smpl_reg <= RST_SMPL[7:0];
			range_reg <= RST_RANGE[10:8];
			exp_reg <= RST_RANGE[3:0];
			sleep_reg <= RST_SLEEP[7:0];
		end else if (wr_en) begin
			case (wr_word)
			`GOC_ADDR_DAC: begin
				// The latch is untouched here, so the output holds between bytes
				if (wr_lo)
					dac_code_reg[7:0] <= wr_data;
				else
					dac_code_reg[11:8] <= wr_data[3:0];
			end
			`GOC_ADDR_IO: begin
				if (wr_lo)
					io_dir_reg <= wr_data[1:0];
				else
					io_lvl_reg <= wr_data[1:0];
			end
			`GOC_ADDR_SMPL: begin
				if (wr_lo)
					smpl_reg <= wr_data;
			end
			`GOC_ADDR_RANGE: begin
				if (wr_lo) begin
					exp_reg <= goc_floor(range_reg, wr_data[3:0]);
				end else begin
					range_reg <= wr_data[2:0];
					exp_reg <= goc_floor(wr_data[2:0], exp_reg);
				end
			end
			`GOC_ADDR_SLEEP: begin
				if (wr_lo)
					sleep_reg <= wr_data;
			end
			`GOC_ADDR_CMD: begin
				if (wr_lo && wr_data[`GOC_CMD_DAC_LATCH_BIT])
					dac_level <= dac_code_reg;
			end
			default: begin
			end
			endcase
		end
	end

	// Sample timer; held in reset while asleep and on any period rewrite
	always @(posedge sys_clk) begin
		if (sys_rst || smpl_wr || state_reg == S_SLEEP) begin
			tb_cnt_reg <= 32'd0;
			tick_cnt_reg <= 7'd0;
			sample_strobe <= 1'b0;
		end else begin
			sample_strobe <= period_done;
			if (tb_tick) begin
				tb_cnt_reg <= 32'd0;
				tick_cnt_reg <= period_done ? 7'd0 : tick_cnt_reg + 7'd1;
			end else begin
				tb_cnt_reg <= tb_cnt_reg + 32'd1;
			end
		end
	end

	// Slow time base is always below 64 SPS; fast base only above N of 7
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			low_power_mode <= 1'b0;
			range_sel <= `GOC_RANGE_320;
			filter_exp <= 4'h0;
		end else begin
			low_power_mode <= smpl_reg[`GOC_SMPL_TB_BIT] || smpl_reg[6:0] > `GOC_FULL_RATE_MAX_N;
			range_sel <= range_reg;
			filter_exp <= exp_lim;
		end
	end

	// Sleep waits for chip-select to rise, since the arming write happens with it low
	always @(posedge sys_clk) begin
		if (sys_rst) begin
			state_reg <= S_RUN;
			half_cnt_reg <= 32'd0;
			remain_reg <= 8'd0;
			sleep_active <= 1'b0;
		end else begin
			sleep_active <= state_reg == S_SLEEP;
			case (state_reg)
			S_RUN: begin
				if (wr_lo && wr_word == `GOC_ADDR_SLEEP && wr_data != 8'd0) begin
					state_reg <= S_ARM;
					remain_reg <= wr_data;
					half_cnt_reg <= 32'd0;
				end
			end
			S_ARM: begin
				// First armed edge still sees the synchroniser level from before the write
				if (cs_sync_reg && half_cnt_reg != 32'd0) begin
					state_reg <= S_SLEEP;
					half_cnt_reg <= 32'd0;
				end else begin
					half_cnt_reg <= 32'd1;
				end
			end
			S_SLEEP: begin
				if (!cs_sync_reg) begin
					state_reg <= S_RUN;
				end else if (half_cnt_reg == SLEEP_LSB_CYC - 1) begin
					half_cnt_reg <= 32'd0;
					remain_reg <= remain_reg - 8'd1;
					if (remain_reg == 8'd1)
						state_reg <= S_RUN;
				end else begin
					half_cnt_reg <= half_cnt_reg + 32'd1;
				end
			end
			default: begin
				state_reg <= S_RUN;
			end
			endcase
		end
	end

	// Pin ownership resolved before the output flops
	always @* begin
		io_oe_next = 2'b00;
		io_out_next = 2'b00;
		for (i = 0; i < 2; i = i + 1) begin
			if (drdy_claim[i]) begin
				io_oe_next[i] = 1'b1;
				io_out_next[i] = drdy_level[i];
			end else if (alarm_claim[i]) begin
				io_oe_next[i] = 1'b1;
				io_out_next[i] = alarm_level[i];
			end else begin
				io_oe_next[i] = io_dir_reg[i];
				io_out_next[i] = io_dir_reg[i] & io_lvl_reg[i];
			end
		end
	end

	always @(posedge sys_clk) begin
		if (sys_rst) begin
			io_pin_out <= 2'b00;
			io_pin_oe <= 2'b00;
		end else begin
			io_pin_out <= io_out_next;
			io_pin_oe <= io_oe_next;
		end
	end

	always @* begin
		rd_next = 16'h0000;
		case (rd_word)
		`GOC_ADDR_DAC: rd_next = {4'h0, dac_code_reg};
		`GOC_ADDR_IO: rd_next = {6'h00, io_lvl_reg, 6'h00, (io_dir_reg & io_lvl_reg) | (~io_dir_reg & io_sync_reg)};
		`GOC_ADDR_SMPL: rd_next = {8'h00, smpl_reg};
		`GOC_ADDR_RANGE: rd_next = {5'h00, range_reg, 4'h0, exp_reg};
		`GOC_ADDR_SLEEP: rd_next = {8'h00, sleep_reg};
		default: rd_next = 16'h0000;
		endcase
	end

	always @(posedge sys_clk) begin
		if (sys_rst) begin
			rd_data <= 16'h0000;
			exp_prev_reg <= 3'd0;
		end else begin
			if (rd_en)
				rd_data <= rd_next;
			exp_prev_reg <= exp_lim[2:0];
		end
	end

	// A changed window length flushes both stages rather than mix windows
	goc_boxcar #(.W(DW), .AW(7)) u_stage1 (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.restart(filt_restart),
		.in_valid(sample_strobe),
		.in_data(raw_data),
		.exp_m(exp_lim[2:0]),
		.out_valid(stage1_valid),
		.out_data(stage1_data)
	);

	goc_boxcar #(.W(DW), .AW(7)) u_stage2 (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.restart(filt_restart),
		.in_valid(stage1_valid),
		.in_data(stage1_data),
		.exp_m(exp_lim[2:0]),
		.out_valid(data_update),
		.out_data(data_out)
	);
endmodule

/* File: logic/goc_map.vh */
`ifndef GOC_MAP_VH
`define GOC_MAP_VH

// Register byte addresses; even address is the low byte, odd the high byte
`define GOC_ADDR_DAC 6'h30
`define GOC_ADDR_IO 6'h32
`define GOC_ADDR_SMPL 6'h36
`define GOC_ADDR_RANGE 6'h38
`define GOC_ADDR_SLEEP 6'h3a
`define GOC_ADDR_CMD 6'h3e

// Reset values
`define GOC_RST_DAC 16'h0000
`define GOC_RST_IO 16'h0000
`define GOC_RST_SMPL 16'h0001
`define GOC_RST_RANGE 16'h0402
`define GOC_RST_SLEEP 16'h0000

// Field positions and codes
`define GOC_SMPL_TB_BIT 7
`define GOC_CMD_DAC_LATCH_BIT 2
`define GOC_RANGE_320 3'h4
`define GOC_RANGE_160 3'h2
`define GOC_RANGE_80 3'h1
`define GOC_MIN_EXP_160 4'h2
`define GOC_MIN_EXP_80 4'h4
`define GOC_MAX_EXP 4'h7
`define GOC_FULL_RATE_MAX_N 7'h07

// Timing
`define GOC_CLK_NS 10
`define GOC_TB_FAST_NS 1953000
`define GOC_TB_SLOW_NS 60540000
`define GOC_SLEEP_LSB_NS 500000000
`define GOC_TB_FAST_CYC (`GOC_TB_FAST_NS / `GOC_CLK_NS)
`define GOC_TB_SLOW_CYC (`GOC_TB_SLOW_NS / `GOC_CLK_NS)
`define GOC_SLEEP_LSB_CYC (`GOC_SLEEP_LSB_NS / `GOC_CLK_NS)

`endif

/* File: logic/goc_boxcar.v */
`timescale 1ns/1ps
// One boxcar stage of 2^exp taps; two in cascade give the triangular window
module goc_boxcar #(
	parameter W = 14,
	parameter AW = 7
) (
	input wire sys_clk,
	input wire sys_rst,
	input wire restart,
	input wire in_valid,
	input wire [W-1:0] in_data,
	input wire [2:0] exp_m,
	output reg out_valid,
	output reg [W-1:0] out_data
);
	localparam SW = W + AW + 1;
	localparam DEPTH = 1 << AW;

	reg [W-1:0] hist [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_reg;
	reg [AW:0] fill_reg;
	reg signed [SW-1:0] sum_reg;

	wire [AW:0] taps = {{AW{1'b0}}, 1'b1} << exp_m;
	wire [AW-1:0] old_idx = wr_ptr_reg - taps[AW-1:0];
	// Until the window has filled, the missing samples count as zero
	wire [W-1:0] old_raw = (fill_reg >= taps) ? hist[old_idx] : {W{1'b0}};
	wire signed [SW-1:0] x_ext = {{(SW-W){in_data[W-1]}}, in_data};
	wire signed [SW-1:0] old_ext = {{(SW-W){old_raw[W-1]}}, old_raw};
	wire signed [SW-1:0] sum_next = sum_reg + x_ext - old_ext;
	wire signed [SW-1:0] avg = sum_next >>> exp_m;

	always @(posedge sys_clk) begin
		if (in_valid)
			hist[wr_ptr_reg] <= in_data;
	end

	always @(posedge sys_clk) begin
		if (sys_rst || restart) begin
			wr_ptr_reg <= {AW{1'b0}};
			fill_reg <= {(AW+1){1'b0}};
			sum_reg <= {SW{1'b0}};
			out_valid <= 1'b0;
			out_data <= {W{1'b0}};
		end else begin
			out_valid <= in_valid;
			if (in_valid) begin
				wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
				// Fill stops at DEPTH, the only count with its top bit set
				if (!fill_reg[AW])
					fill_reg <= fill_reg + {{AW{1'b0}}, 1'b1};
				sum_reg <= sum_next;
				out_data <= avg[W-1:0];
			end
		end
	end
endmodule

/* File: dv/goc_ctrl_chk.sv */
`timescale 1ns/1ps
module goc_ctrl_chk (
	input wire sys_clk,
	input wire sys_rst,
	input wire wr_en,
	input wire [5:0] wr_addr,
	input wire [7:0] wr_data,
	input wire cs_n_pin,
	input wire [1:0] drdy_claim,
	input wire [1:0] drdy_level,
	input wire [1:0] io_pin_out,
	input wire [1:0] io_pin_oe,
	input wire sample_strobe,
	input wire low_power_mode,
	input wire sleep_active,
	input wire [2:0] range_sel,
	input wire [3:0] filter_exp,
	input wire [11:0] dac_level
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	wire latch_hit = wr_en && wr_addr == 6'h3e && wr_data[2];
	sequence s_latch; latch_hit; endsequence
	sequence s_cs_low; !cs_n_pin [*5]; endsequence
	property p_rst_val; $fell(sys_rst) |-> dac_level == 12'h000 && range_sel == 3'h4; endproperty
	a_rst_val: assert property (p_rst_val) else $error("reset value wrong");
	property p_dac_hold; $changed(dac_level) |-> $past(latch_hit); endproperty
	a_dac_hold: assert property (p_dac_hold) else $error("dac moved without latch");
	property p_range; wr_en && wr_addr == 6'h39 |=> ##1 {5'h0, range_sel} == ($past(wr_data, 2) & 8'h07); endproperty
	a_range: assert property (p_range) else $error("range code not stored");
	property p_floor; wr_en && wr_addr == 6'h39 && wr_data[2:0] == 3'h1 |=> ##2 filter_exp >= 4'h4; endproperty
	a_floor: assert property (p_floor) else $error("exponent floor missing");
	property p_strobe; sample_strobe |=> !sample_strobe [*8]; endproperty
	a_strobe: assert property (p_strobe) else $error("strobe too long or too close");
	property p_lp; wr_en && wr_addr == 6'h36 |=> ##1 low_power_mode == ($past(wr_data, 2) > 8'h07); endproperty
	a_lp: assert property (p_lp) else $error("power mode wrong");
	property p_wake; s_cs_low |=> !sleep_active; endproperty
	a_wake: assert property (p_wake) else $error("no wake on select");
	property p_prio; drdy_claim[0] |=> io_pin_oe[0] && {1'b0, io_pin_out[0]} == ($past(drdy_level) & 2'b01); endproperty
	a_prio: assert property (p_prio) else $error("line priority wrong");
	c_latch: cover property (s_latch);
endmodule
bind goc_ctrl goc_ctrl_chk u_chk (
	.sys_clk(sys_clk),
	.sys_rst(sys_rst),
	.wr_en(wr_en),
	.wr_addr(wr_addr),
	.wr_data(wr_data),
	.cs_n_pin(cs_n_pin),
	.drdy_claim(drdy_claim),
	.drdy_level(drdy_level),
	.io_pin_out(io_pin_out),
	.io_pin_oe(io_pin_oe),
	.sample_strobe(sample_strobe),
	.low_power_mode(low_power_mode),
	.sleep_active(sleep_active),
	.range_sel(range_sel),
	.filter_exp(filter_exp),
	.dac_level(dac_level)
);

/* File: dv/goc_host.sv */
`timescale 1ns/1ps
// Register host; changes signals on falling edges so the device samples settled values
module goc_host (
	input wire sys_clk,
	output logic wr_en,
	output logic [5:0] wr_addr,
	output logic [7:0] wr_data,
	output logic rd_en,
	output logic [5:0] rd_addr,
	input wire [15:0] rd_data,
	output logic cs_n_pin
);
	initial begin
		{wr_en, rd_en, wr_addr, rd_addr, wr_data} = '0;
		cs_n_pin = 1'b1;
	end
	// Select low only during an access or hold_cs, so idling never wakes a sleeping device
	task wr(input logic [5:0] a, input logic [7:0] d);
		@(negedge sys_clk);
		{cs_n_pin, wr_en, wr_addr, wr_data} = {2'b01, a, d};
		@(negedge sys_clk);
		{cs_n_pin, wr_en} = 2'b10;
	endtask
	task wr16(input logic [5:0] a, input logic [15:0] d);
		wr(a | 6'h01, d[15:8]);
		wr(a, d[7:0]);
	endtask
	task rd(input logic [5:0] a, output logic [15:0] q);
		@(negedge sys_clk);
		{cs_n_pin, rd_en, rd_addr} = {2'b01, a};
		@(negedge sys_clk);
		{cs_n_pin, rd_en} = 2'b10;
		q = rd_data;
	endtask
	task hold_cs(input int k);
		@(negedge sys_clk);
		cs_n_pin = 1'b0;
		repeat (k) @(negedge sys_clk);
		cs_n_pin = 1'b1;
	endtask
	// Access pace follows the device clock; there is no serial clock to limit
endmodule

/* File: dv/goc_ctrl_tb_top.sv */
`timescale 1ns/1ps
`define CHK(n,e,g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; $display("[ERR] %s exp %h got %h", n, e, g); end end
module goc_ctrl_tb_top;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic wr_en, rd_en, cs_n_pin, data_update, sample_strobe, low_power_mode, sleep_active;
	logic [5:0] wr_addr, rd_addr;
	logic [7:0] wr_data;
	logic [15:0] rd_data;
	logic [1:0] io_pin_in, io_pin_out, io_pin_oe, drdy_claim, drdy_level, alarm_claim, alarm_level;
	logic [13:0] raw_data, data_out;
	logic [2:0] range_sel;
	logic [3:0] filter_exp;
	logic [11:0] dac_level;
	int error_cnt = 0;
	int n_checks = 0;
	// Short time bases keep the run brief
	goc_ctrl #(.TB_FAST_CYC(10), .TB_SLOW_CYC(40), .SLEEP_LSB_CYC(20)) dut (
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.rd_en(rd_en),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.cs_n_pin(cs_n_pin),
		.io_pin_in(io_pin_in),
		.io_pin_out(io_pin_out),
		.io_pin_oe(io_pin_oe),
		.drdy_claim(drdy_claim),
		.drdy_level(drdy_level),
		.alarm_claim(alarm_claim),
		.alarm_level(alarm_level),
		.raw_data(raw_data),
		.data_out(data_out),
		.data_update(data_update),
		.sample_strobe(sample_strobe),
		.low_power_mode(low_power_mode),
		.sleep_active(sleep_active),
		.range_sel(range_sel),
		.filter_exp(filter_exp),
		.dac_level(dac_level)
	);
	goc_host h (
		.sys_clk(sys_clk),
		.wr_en(wr_en),
		.wr_addr(wr_addr),
		.wr_data(wr_data),
		.rd_en(rd_en),
		.rd_addr(rd_addr),
		.rd_data(rd_data),
		.cs_n_pin(cs_n_pin)
	);
	always #5 sys_clk = ~sys_clk;
	task print_verdict;
		if (error_cnt == 0 && n_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task t_reset;
		logic [15:0] q;
		logic [5:0] a [6] = '{6'h30, 6'h32, 6'h36, 6'h38, 6'h3a, 6'h3c};
		logic [15:0] e [6] = '{16'h0000, 16'h0000, 16'h0001, 16'h0402, 16'h0000, 16'h0000};
		for (int i = 0; i < 6; i++) begin
			h.rd(a[i], q);
			`CHK("reset", e[i], q)
		end
	endtask
	task t_dac;
		logic [15:0] q;
		h.wr16(6'h30, 16'hfcab);
		`CHK("dac_hold", 12'h000, dac_level)
		h.rd(6'h30, q);
		`CHK("dac_reg", 16'h0cab, q)
		h.wr(6'h3e, 8'h04);
		@(negedge sys_clk);
		`CHK("dac_latch", 12'hcab, dac_level)
	endtask
	task t_range;
		logic [15:0] q;
		logic [2:0] c [3] = '{3'h4, 3'h2, 3'h1};
		logic [3:0] m [3] = '{4'h0, 4'h2, 4'h4};
		for (int i = 0; i < 3; i++) begin
			h.wr16(6'h38, {5'h0, c[i], 8'h00});
			h.rd(6'h38, q);
			`CHK("range", {5'h0, c[i], 4'h0, m[i]}, q)
		end
		h.wr16(6'h38, 16'h0105);
		h.rd(6'h38, q);
		`CHK("exp", 16'h0105, q)
		`CHK("exp_use", 4'h5, filter_exp)
	endtask
	task meas(input logic [7:0] v, input int p, input logic lp);
		int n;
		h.wr(6'h36, v);
		n = 0;
		while (sample_strobe !== 1'b1 && n < 500) begin
			@(negedge sys_clk);
			n++;
		end
		n = 0;
		do begin
			@(negedge sys_clk);
			n++;
		end while (sample_strobe !== 1'b1 && n < 500);
		`CHK("period", p, n)
		`CHK("low_power", lp, low_power_mode)
	endtask
	task t_sleep;
		int n;
		h.wr(6'h3a, 8'h02);
		for (n = 0; n < 20 && sleep_active !== 1'b1; n++) @(negedge sys_clk);
		n = 0;
		while (sleep_active === 1'b1 && n < 200) begin
			@(negedge sys_clk);
			n++;
		end
		`CHK("sleep_len", 1'b1, n >= 38 && n <= 42)
		h.wr(6'h3a, 8'h05);
		repeat (10) @(negedge sys_clk);
		`CHK("asleep", 1'b1, sleep_active)
		h.hold_cs(8);
		`CHK("wake", 1'b0, sleep_active)
	endtask
	task t_io;
		logic [15:0] q;
		h.wr16(6'h32, 16'h0101);
		@(negedge sys_clk);
		`CHK("oe", 2'b01, io_pin_oe)
		`CHK("lvl", 1'b1, io_pin_out[0])
		alarm_claim = 2'b01;
		@(negedge sys_clk);
		`CHK("alarm", 1'b0, io_pin_out[0])
		drdy_claim = 2'b01;
		drdy_level = 2'b01;
		@(negedge sys_clk);
		`CHK("drdy", 1'b1, io_pin_out[0])
		drdy_claim = 2'b00;
		alarm_claim = 2'b00;
		h.wr16(6'h32, 16'h0000);
		io_pin_in = 2'b10;
		repeat (3) @(negedge sys_clk);
		h.rd(6'h32, q);
		`CHK("pins", 16'h0002, q)
	endtask
	task t_filt;
		h.wr(6'h36, 8'h01);
		h.wr16(6'h38, 16'h0401);
		raw_data = 14'h0123;
		repeat (6) begin
			for (int n = 0; n < 100 && data_update !== 1'b1; n++) @(negedge sys_clk);
			@(negedge sys_clk);
		end
		`CHK("filt", 14'h0123, data_out)
	endtask
	initial begin
		{io_pin_in, drdy_claim, drdy_level, alarm_claim, alarm_level} = '0;
		raw_data = '0;
		repeat (10) @(negedge sys_clk);
		sys_rst = 1'b0;
		t_reset;
		t_dac;
		t_range;
		meas(8'h02, 30, 1'b0);
		meas(8'h08, 90, 1'b1);
		meas(8'h07, 80, 1'b0);
		meas(8'h80, 40, 1'b1);
		t_sleep;
		t_io;
		t_filt;
		print_verdict;
	end
	// Whole run needs under a thousand cycles; this margin only catches a hang
	initial begin
		repeat (20000) @(posedge sys_clk);
		error_cnt++;
		print_verdict;
	end
endmodule
